// ---- lad_pkg.sv ----
// Shared constants and carrier types for the light converter core
package lad_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OSC_HZ = 735_000;
  // Oscillator tick every OSC_DIV clocks, nominal rate
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
  localparam logic [7:0] OSC_DIV_LAST = 8'(OSC_DIV - 1);

  localparam int unsigned BASE_CYC = 918;
  localparam int unsigned MULT_00 = 11;
  localparam int unsigned MULT_01 = 81;
  localparam int unsigned MULT_10 = 322;
  localparam int unsigned CYC_W = 19;
  localparam logic [CYC_W-1:0] LAST_00 = CYC_W'(MULT_00 * BASE_CYC - 1);
  localparam logic [CYC_W-1:0] LAST_01 = CYC_W'(MULT_01 * BASE_CYC - 1);
  localparam logic [CYC_W-1:0] LAST_10 = CYC_W'(MULT_10 * BASE_CYC - 1);

  // Count slots are odd cycles; the first OFFSET of them are lost
  localparam int unsigned OFFSET = 2;
  localparam logic [CYC_W-1:0] FIRST_SLOT = CYC_W'(2 * OFFSET + 1);
  localparam logic [15:0] FULL_SCALE = 16'hFFFF;
  localparam logic [3:0] LOW_GAIN_LAST = 4'hF;

  localparam logic [6:0] ADDR_GND = 7'h29;
  localparam logic [6:0] ADDR_FLOAT = 7'h39;
  localparam logic [6:0] ADDR_VDD = 7'h49;
  localparam logic [6:0] ADDR_ALERT = 7'h0C;

  localparam int unsigned CMD_BIT = 7;
  localparam logic [3:0] SEL_BB_LO = 4'hC;
  localparam logic [3:0] SEL_BB_HI = 4'hD;
  localparam logic [3:0] SEL_IR_LO = 4'hE;
  localparam logic [3:0] SEL_IR_HI = 4'hF;

  localparam int unsigned TIMEOUT_MS = 25;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    LAD_STRAP_GND = 2'h0,
    LAD_STRAP_FLOAT = 2'h1,
    LAD_STRAP_VDD = 2'h2
  } lad_strap_t;

  typedef enum logic [1:0] {
    LAD_IT_SHORT = 2'h0,
    LAD_IT_MID = 2'h1,
    LAD_IT_LONG = 2'h2,
    LAD_IT_HALT = 2'h3
  } lad_itime_t;

  typedef struct packed {
    logic gain_low;
    lad_itime_t itime;
  } lad_cfg_t;

  typedef enum logic [2:0] {
    LAD_IDLE = 3'h0,
    LAD_ADDR = 3'h1,
    LAD_AACK = 3'h3,
    LAD_RX = 3'h2,
    LAD_RXACK = 3'h6,
    LAD_TX = 3'h7,
    LAD_TXACK = 3'h5
  } lad_state_t;
endpackage : lad_pkg

// ---- lad_core.sv ----
// Light converter core: dual integrators and two-wire register slave
module lad_core #(
  parameter int unsigned TIMEOUT_CYC = lad_pkg::TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input lad_pkg::lad_cfg_t cfg,
  input wire logic smbus_mode_en,
  input lad_pkg::lad_strap_t addr_strap,
  input wire logic broadband_pulse,
  input wire logic infrared_pulse,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  // Pin sampling: bit 0 scl, 1 sda, 2 broadband, 3 infrared
  logic [3:0] sync1_q, sync2_q, sync3_q, filt_q, prev_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic osc_tick, period_end, slot, busy, tmo;
  logic [7:0] div_q;
  logic [lad_pkg::CYC_W-1:0] cyc_q, last_cyc;
  logic [1:0] pend_q, hit;
  logic [3:0] pre_q [2];
  logic [15:0] acc_q [2];
  logic [15:0] shadow_q [2];
  logic [15:0] data_q [2];
  logic xfer_q;
  logic [6:0] slave_addr_q;
  logic strap_done_q;
  logic [21:0] tmo_q;
  lad_pkg::lad_state_t state_q;
  logic [3:0] cnt_q, sel_q;
  logic [7:0] sh_q, tx_q;
  logic rw_q, alert_q, mack_q, oe_q;
  logic [7:0] next_byte;

  function automatic logic [7:0] rd_byte(input logic [3:0] sel,
                                         input logic alert,
                                         input logic [6:0] addr,
                                         input logic [15:0] bb,
                                         input logic [15:0] ir);
    logic [7:0] b;
    b = 8'h00;
    if (alert)
      b = {addr, 1'b0};
    else
      unique case (sel)
        lad_pkg::SEL_BB_LO: b = bb[7:0];
        lad_pkg::SEL_BB_HI: b = bb[15:8];
        lad_pkg::SEL_IR_LO: b = ir[7:0];
        lad_pkg::SEL_IR_HI: b = ir[15:8];
        default: b = 8'h00;
      endcase
    return b;
  endfunction

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
      sync3_q <= 4'hF;
      filt_q <= 4'hF;
      prev_q <= 4'hF;
    end
    else
    begin
      sync1_q <= {infrared_pulse, broadband_pulse, sda_in, scl_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      // Change accepted once the two later stages agree
      filt_q <= (sync2_q & sync3_q) | (filt_q & (sync2_q | sync3_q));
      prev_q <= filt_q;
    end
  end

  assign scl_rise = filt_q[0] & ~prev_q[0];
  assign scl_fall = ~filt_q[0] & prev_q[0];
  assign bus_start = filt_q[0] & prev_q[0] & prev_q[1] & ~filt_q[1];
  assign bus_stop = filt_q[0] & prev_q[0] & ~prev_q[1] & filt_q[1];

  // Oscillator time base
  always_ff @(posedge clk)
  begin
    if (!rst_n || osc_tick)
      div_q <= 8'h00;
    else
      div_q <= div_q + 8'h01;
  end
  assign osc_tick = div_q == lad_pkg::OSC_DIV_LAST;

  always_comb
  begin
    unique case (cfg.itime)
      lad_pkg::LAD_IT_SHORT: last_cyc = lad_pkg::LAST_00;
      lad_pkg::LAD_IT_MID: last_cyc = lad_pkg::LAST_01;
      lad_pkg::LAD_IT_LONG: last_cyc = lad_pkg::LAST_10;
      lad_pkg::LAD_IT_HALT: last_cyc = '1;
    endcase
  end

  // Halt code holds the period open: nothing is ever transferred
  assign period_end = osc_tick && cfg.itime != lad_pkg::LAD_IT_HALT &&
                      cyc_q >= last_cyc;
  assign slot = osc_tick && cyc_q[0] && cyc_q >= lad_pkg::FIRST_SLOT;

  always_ff @(posedge clk)
  begin
    if (!rst_n || period_end)
      cyc_q <= '0;
    else if (osc_tick && cyc_q != '1)
      cyc_q <= cyc_q + lad_pkg::CYC_W'(1);
  end

  // Light events wait for the next count slot; a new event beats consume
  assign hit = pend_q & {2{slot}};
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pend_q <= 2'b00;
    else
      pend_q <= (filt_q[3:2] & ~prev_q[3:2]) | (pend_q & ~hit);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 2; i++)
      begin
        acc_q[i] <= 16'h0000;
        pre_q[i] <= 4'h0;
        shadow_q[i] <= 16'h0000;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (period_end)
        begin
          shadow_q[i] <= acc_q[i];
          acc_q[i] <= 16'h0000;
          pre_q[i] <= 4'h0;
        end
        else if (hit[i])
        begin
          pre_q[i] <= cfg.gain_low ? pre_q[i] + 4'h1 : 4'h0;
          if ((!cfg.gain_low || pre_q[i] == lad_pkg::LOW_GAIN_LAST) &&
              acc_q[i] != lad_pkg::FULL_SCALE)
            acc_q[i] <= acc_q[i] + 16'h0001;
        end
      end
    end
  end

  // Readable copy only moves while no transaction is running
  assign busy = state_q != lad_pkg::LAD_IDLE;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      xfer_q <= 1'b0;
      data_q[0] <= 16'h0000;
      data_q[1] <= 16'h0000;
    end
    else if (period_end)
      xfer_q <= 1'b1;
    else if (xfer_q && !busy)
    begin
      xfer_q <= 1'b0;
      data_q[0] <= shadow_q[0];
      data_q[1] <= shadow_q[1];
    end
  end

  // Strap sampled once, on the first edge after reset release
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      strap_done_q <= 1'b0;
      slave_addr_q <= lad_pkg::ADDR_FLOAT;
    end
    else if (!strap_done_q)
    begin
      strap_done_q <= 1'b1;
      unique case (addr_strap)
        lad_pkg::LAD_STRAP_GND: slave_addr_q <= lad_pkg::ADDR_GND;
        lad_pkg::LAD_STRAP_VDD: slave_addr_q <= lad_pkg::ADDR_VDD;
        default: slave_addr_q <= lad_pkg::ADDR_FLOAT;
      endcase
    end
  end

  // Low-line watchdog; saturates so it fires once per stuck episode
  always_ff @(posedge clk)
  begin
    if (!rst_n || !smbus_mode_en || (filt_q[0] && filt_q[1]))
      tmo_q <= 22'h000000;
    else if (tmo_q != 22'(TIMEOUT_CYC))
      tmo_q <= tmo_q + 22'h000001;
  end
  assign tmo = tmo_q == 22'(TIMEOUT_CYC - 1);

  // Byte a read would shift out next, from the current select
  assign next_byte = rd_byte(sel_q, alert_q, slave_addr_q, data_q[0],
                             data_q[1]);

  always_ff @(posedge clk)
  begin
    if (!rst_n || tmo || bus_stop)
    begin
      state_q <= lad_pkg::LAD_IDLE;
      oe_q <= 1'b0;
      cnt_q <= 4'h0;
      if (!rst_n)
      begin
        sel_q <= 4'h0;
        sh_q <= 8'h00;
        tx_q <= 8'h00;
        rw_q <= 1'b0;
        alert_q <= 1'b0;
        mack_q <= 1'b0;
      end
    end
    else if (bus_start)
    begin
      state_q <= lad_pkg::LAD_ADDR;
      oe_q <= 1'b0;
      cnt_q <= 4'h0;
    end
    else
    begin
      if (scl_rise && cnt_q != 4'h8)
      begin
        sh_q <= {sh_q[6:0], filt_q[1]};
        cnt_q <= cnt_q + 4'h1;
      end
      unique case (state_q)
        lad_pkg::LAD_IDLE: ;
        lad_pkg::LAD_ADDR:
          if (scl_fall && cnt_q == 4'h8)
          begin
            // Low bit of the byte is the master's direction bit
            if (sh_q[7:1] == slave_addr_q ||
                sh_q[7:1] == lad_pkg::ADDR_ALERT)
            begin
              state_q <= lad_pkg::LAD_AACK;
              oe_q <= 1'b1;
              rw_q <= sh_q[0];
              alert_q <= sh_q[7:1] == lad_pkg::ADDR_ALERT;
            end
            else
              state_q <= lad_pkg::LAD_IDLE;
          end
        lad_pkg::LAD_AACK, lad_pkg::LAD_RXACK:
          if (scl_fall)
          begin
            cnt_q <= 4'h0;
            if (state_q == lad_pkg::LAD_AACK && rw_q)
            begin
              state_q <= lad_pkg::LAD_TX;
              tx_q <= next_byte;
              oe_q <= ~next_byte[7];
              sel_q <= sel_q + 4'h1;
            end
            else
            begin
              state_q <= lad_pkg::LAD_RX;
              oe_q <= 1'b0;
            end
          end
        lad_pkg::LAD_RX:
          if (scl_fall && cnt_q == 4'h8)
          begin
            state_q <= lad_pkg::LAD_RXACK;
            oe_q <= 1'b1;
            // Other bytes would go to registers outside this core
            if (sh_q[lad_pkg::CMD_BIT])
              sel_q <= sh_q[3:0];
          end
        lad_pkg::LAD_TX:
          if (scl_fall)
          begin
            if (cnt_q == 4'h8)
            begin
              state_q <= lad_pkg::LAD_TXACK;
              oe_q <= 1'b0;
            end
            else
              oe_q <= ~tx_q[3'(4'h7 - cnt_q)];
          end
        lad_pkg::LAD_TXACK:
        begin
          if (scl_rise)
            mack_q <= ~filt_q[1];
          if (scl_fall)
          begin
            cnt_q <= 4'h0;
            if (mack_q)
            begin
              state_q <= lad_pkg::LAD_TX;
              tx_q <= next_byte;
              oe_q <= ~next_byte[7];
              sel_q <= sel_q + 4'h1;
            end
            else
              state_q <= lad_pkg::LAD_IDLE;
          end
        end
      endcase
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;

  a_osc_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    osc_tick |=> !osc_tick [*8])
    else $error("oscillator tick too soon");

  a_period_restart: assert property (@(posedge clk) disable iff (!rst_n)
    period_end |=> cyc_q == '0 && acc_q[0] == 16'h0000)
    else $error("period did not restart");

  a_period_length: assert property (@(posedge clk) disable iff (!rst_n)
    period_end && cfg.itime == lad_pkg::LAD_IT_SHORT
    |-> cyc_q == lad_pkg::LAST_00)
    else $error("short period length wrong");

  a_count_slot: assert property (@(posedge clk) disable iff (!rst_n)
    acc_q[0] != $past(acc_q[0]) && !$past(period_end)
    |-> $past(cyc_q[0]) && $past(cyc_q) >= lad_pkg::FIRST_SLOT)
    else $error("count outside slot");

  a_sat_hold: assert property (@(posedge clk) disable iff (!rst_n)
    acc_q[1] == lad_pkg::FULL_SCALE && !period_end
    |=> acc_q[1] == lad_pkg::FULL_SCALE)
    else $error("accumulator wrapped");

  a_low_gain_step: assert property (@(posedge clk) disable iff (!rst_n)
    cfg.gain_low && $past(cfg.gain_low) && !$past(period_end) &&
    acc_q[0] != $past(acc_q[0])
    |-> $past(pre_q[0]) == lad_pkg::LOW_GAIN_LAST)
    else $error("low gain step early");

  a_shadow_capture: assert property (@(posedge clk) disable iff (!rst_n)
    period_end |=> shadow_q[0] == $past(acc_q[0]) &&
                   shadow_q[1] == $past(acc_q[1]))
    else $error("result not captured");

  a_data_stable_busy: assert property (@(posedge clk) disable iff (!rst_n)
    busy && $past(busy) |-> $stable(data_q[0]) && $stable(data_q[1]))
    else $error("readable data moved mid transfer");

  a_addr_match: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == lad_pkg::LAD_AACK && $past(state_q) == lad_pkg::LAD_ADDR
    |-> $past(sh_q[7:1]) == slave_addr_q ||
        $past(sh_q[7:1]) == lad_pkg::ADDR_ALERT)
    else $error("acked foreign address");

  a_cmd_select: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == lad_pkg::LAD_RX && scl_fall && cnt_q == 4'h8 &&
    sh_q[lad_pkg::CMD_BIT] && !bus_stop && !tmo
    |=> sel_q == $past(sh_q[3:0]))
    else $error("command select not stored");

  a_timeout_idle: assert property (@(posedge clk) disable iff (!rst_n)
    tmo |=> state_q == lad_pkg::LAD_IDLE && !sda_oe)
    else $error("timeout did not free bus");
endmodule // lad_core

// ---- lad_host.sv ----
// Two-wire bus host model that drives the converter's slave port
module lad_host (
  input wire logic clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus: clock stands high, data released to its pull-up
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // One quarter of the 160 ns bus period, far faster than a real host
  task automatic q(input int n);
    repeat (4 * n) @(negedge clk);
  endtask

  // Works from idle and as a repeated start alike
  task automatic start();
    sda_low = 1'b0;
    q(1);
    scl = 1'b1;
    q(2);
    sda_low = 1'b1;
    q(2);
    scl = 1'b0;
  endtask

  // Data set mid-low, line sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    q(1);
    sda_low = !b;
    q(1);
    scl = 1'b1;
    q(1);
    s = sda_w;
    q(1);
    scl = 1'b0;
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask

  // Host acks every byte but the last, which it refuses
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(last, s);
  endtask

  task automatic address(input logic [6:0] a, input logic rw,
    output logic ack);
    wr_byte({a, rw}, ack);
  endtask

  task automatic stop();
    q(1);
    sda_low = 1'b1;
    q(1);
    scl = 1'b1;
    q(1);
    sda_low = 1'b0;
    q(2);
  endtask
endmodule // lad_host

// ---- tb_top.sv ----
// Self-checking bench for the light converter core
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    lad_pkg::lad_strap_t strap;
    logic [6:0] addr;
    logic ack;
  } lad_row_t;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  lad_pkg::lad_cfg_t cfg = '0;
  logic smbus_mode_en = 1'b0;
  lad_pkg::lad_strap_t addr_strap = lad_pkg::LAD_STRAP_GND;
  logic broadband_pulse = 1'b0;
  logic infrared_pulse = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic sda_w;
  logic [7:0] pulse_cnt = 8'h00;
  int error_cnt = 0;
  int checks_done = 0;
  lad_row_t rows [11];
  logic a;
  logic [7:0] d;

  always #5 clk = ~clk;

  // Open-drain wire with pull-up: low while either party pulls
  assign sda_w = !((sda_oe && !sda_out) || sda_low);

  // Light keeps arriving; no period completes within this short run
  always @(negedge clk)
  begin
    pulse_cnt <= pulse_cnt + 8'h01;
    broadband_pulse <= pulse_cnt[2];
    infrared_pulse <= pulse_cnt[4];
  end

  lad_core #(.TIMEOUT_CYC(2000)) u_dut (
    .clk(clk),
    .rst_n(rst_n),
    .cfg(cfg),
    .smbus_mode_en(smbus_mode_en),
    .addr_strap(addr_strap),
    .broadband_pulse(broadband_pulse),
    .infrared_pulse(infrared_pulse),
    .scl_in(scl),
    .sda_in(sda_w),
    .sda_out(sda_out),
    .sda_oe(sda_oe)
  );

  lad_host u_host (
    .clk(clk),
    .sda_w(sda_w),
    .scl(scl),
    .sda_low(sda_low)
  );

  task automatic check(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Strap is captured only once after reset, so each case resets
  task automatic rst(input lad_pkg::lad_strap_t strap);
    @(negedge clk);
    rst_n = 1'b0;
    addr_strap = strap;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    check("sda_oe after reset", 8'h00, {7'h00, sda_oe});
  endtask

  // Host parks the clock low right after the address byte, while acked
  task automatic stall_case(input logic en);
    logic s;
    rst(lad_pkg::LAD_STRAP_GND);
    smbus_mode_en = en;
    u_host.start();
    for (int i = 7; i >= 0; i--)
      u_host.bit_io(lad_pkg::ADDR_GND[i > 0 ? i - 1 : 0] & (i > 0), s);
    u_host.q(2);
    check("ack during stall", 8'h01, {7'h00, sda_oe});
    repeat (1500) @(negedge clk);
    check("ack before timeout", 8'h01, {7'h00, sda_oe});
    repeat (700) @(negedge clk);
    check("ack after timeout", {7'h00, !en}, {7'h00, sda_oe});
    u_host.bit_io(1'b1, s);
    u_host.stop();
    u_host.start();
    u_host.address(lad_pkg::ADDR_GND, 1'b0, a);
    u_host.stop();
    check("ack after stall", 8'h01, {7'h00, a});
    smbus_mode_en = 1'b0;
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  initial
  begin
    rows[0] = '{lad_pkg::LAD_STRAP_GND, 7'h29, 1'b1};
    rows[1] = '{lad_pkg::LAD_STRAP_GND, 7'h39, 1'b0};
    rows[2] = '{lad_pkg::LAD_STRAP_GND, 7'h49, 1'b0};
    rows[3] = '{lad_pkg::LAD_STRAP_FLOAT, 7'h39, 1'b1};
    rows[4] = '{lad_pkg::LAD_STRAP_FLOAT, 7'h29, 1'b0};
    rows[5] = '{lad_pkg::LAD_STRAP_VDD, 7'h49, 1'b1};
    rows[6] = '{lad_pkg::LAD_STRAP_VDD, 7'h39, 1'b0};
    rows[7] = '{lad_pkg::LAD_STRAP_GND, 7'h0C, 1'b1};
    rows[8] = '{lad_pkg::LAD_STRAP_VDD, 7'h0C, 1'b1};
    rows[9] = '{lad_pkg::LAD_STRAP_FLOAT, 7'h0D, 1'b0};
    rows[10] = '{lad_pkg::lad_strap_t'(2'h3), 7'h39, 1'b1};
    for (int i = 0; i < 11; i++)
    begin
      rst(rows[i].strap);
      u_host.start();
      u_host.address(rows[i].addr, 1'b0, a);
      u_host.stop();
      check("address ack", {7'h00, rows[i].ack}, {7'h00, a});
    end
    // Alert address answers with the strapped address, repeatedly
    rst(lad_pkg::LAD_STRAP_FLOAT);
    u_host.start();
    u_host.address(7'h0C, 1'b1, a);
    u_host.rd_byte(1'b0, d);
    check("alert byte 0", 8'h72, d);
    u_host.rd_byte(1'b1, d);
    check("alert byte 1", 8'h72, d);
    u_host.stop();
    // Command, ignored data byte, then a combined read through the wrap
    rst(lad_pkg::LAD_STRAP_GND);
    cfg = {1'b1, lad_pkg::LAD_IT_SHORT};
    u_host.start();
    u_host.address(lad_pkg::ADDR_GND, 1'b0, a);
    u_host.wr_byte(8'h8C, a);
    check("command ack", 8'h01, {7'h00, a});
    u_host.wr_byte(8'h05, a);
    check("data byte ack", 8'h01, {7'h00, a});
    u_host.start();
    u_host.address(lad_pkg::ADDR_GND, 1'b1, a);
    check("read address ack", 8'h01, {7'h00, a});
    for (int i = 0; i < 5; i++)
    begin
      u_host.rd_byte(i == 4, d);
      check("result byte", 8'h00, d);
    end
    u_host.stop();
    stall_case(1'b1);
    stall_case(1'b0);
    final_report();
  end
endmodule // tb_top
